// [uart_receive_buffer_status_tb_top.sv]
// Testbench of the receive buffer: APB master, expectation queue and read monitor.
// Assumes the package, the design and the remote transmitter model are compiled first.
`timescale 1ns/1ps
`include "urbs_regs.svh"

module uart_receive_buffer_status_tb_top;
   logic mclk, rst_n, psel, penable, pwrite, global_irq_en, pready, pslverr, rx_irq, rx_pin_claim;
   logic frame_valid, frame_parity, frame_stop1, start_detect, rx_complete_irq_en, gie_m;
   logic [31:0] paddr, pwdata, prdata, lfsr;
   logic [8:0] frame_data, d;
   logic [2:0] csz;
   logic [1:0] upm;
   logic [32:0] expq[$];
   logic [11:0] mq[$];
   int miscompares, check_count, cycles;

   urbs_rx_buffer #(.RX_DEPTH(2)) dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_valid(frame_valid), .frame_data(frame_data), .frame_parity(frame_parity),
      .frame_stop1(frame_stop1), .start_detect(start_detect), .global_irq_en(global_irq_en),
      .rx_irq(rx_irq), .rx_pin_claim(rx_pin_claim));
   urbs_remote_tx rtx_u (.mclk(mclk), .frame_valid(frame_valid), .frame_data(frame_data),
      .frame_parity(frame_parity), .frame_stop1(frame_stop1), .start_detect(start_detect));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Entry layout {overrun, frame err, parity err, data}
   function automatic logic [11:0] ent(input logic [8:0] x, input logic p, input logic s, input logic o);
      logic [8:0] m;
      m = (csz == `URBS_CSZ_NINE) ? 9'h1ff : 9'((9'h020 << csz) - 9'h001);
      return {o, ~s, upm[1] & (^(x & m) ^ p ^ upm[0]), x & m};
   endfunction

   task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] v, input logic [32:0] e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      if (!w) expq.push_back(e);
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   // Status first, then ninth bit, then data, as a handler must
   task automatic rd_entry;
      logic [11:0] e;
      e = mq.pop_front();
      apb(1'b0, `URBS_OFF_STATUS, 32'h0, {25'h0, 1'b1, 2'b0, e[10], e[11], e[9], 2'b0});
      check({32'h0, rx_irq}, {32'h0, rx_complete_irq_en & gie_m}, "irq level");
      apb(1'b0, `URBS_OFF_CTRL_B, 32'h0, {25'h0, rx_complete_irq_en, 2'b0, 1'b1, 2'b0, e[8], 1'b0});
      apb(1'b0, `URBS_OFF_DATA, 32'h0, {25'h0, e[7:0]});
   endtask

   task automatic frame(input logic s, input logic o, input logic keep);
      lfsr = nxt(lfsr);
      d = lfsr[8:0] & {csz == `URBS_CSZ_NINE, 8'hff};
      rtx_u.send(d, lfsr[11], s, int'(lfsr[15:13]));
      if (keep) mq.push_back(ent(d, lfsr[11], s, o));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         report_and_stop();
      end
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check({pslverr, prdata}, expq.pop_front(), "read data");
      end
   end

   initial begin
      {rst_n, psel, penable, pwrite, global_irq_en, rx_complete_irq_en, gie_m} = 7'h00;
      {paddr, pwdata} = 64'h0;
      {miscompares, check_count, cycles} = 96'h0;
      lfsr = 32'h16d4;
      csz = 3'h3;
      upm = 2'h0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      apb(1'b0, `URBS_OFF_CTRL_B, 32'h0, 33'h0);
      apb(1'b0, `URBS_OFF_CTRL_C, 32'h0, {30'h0, `URBS_RST_CSZ});
      apb(1'b0, `URBS_OFF_STATUS, 32'h0, 33'h0);
      apb(1'b0, 32'h10, 32'h0, {1'b1, 32'h0});
      rx_complete_irq_en = 1'b1;
      apb(1'b1, `URBS_OFF_CTRL_B, 32'h90, 33'h0);
      check({32'h0, rx_pin_claim}, 33'h1, "pin claim on");
      // Every size, both parities and checking off, back to back frames
      for (int i = 0; i < 10; i++) begin
         lfsr = nxt(lfsr);
         csz = (i % 5 == 4) ? 3'h7 : 3'(i % 5);
         upm = (i < 5) ? {1'b1, i[0]} : 2'(i % 3);
         gie_m = lfsr[9];
         global_irq_en <= gie_m;
         apb(1'b1, `URBS_OFF_CTRL_C, {26'h0, upm, lfsr[10], csz}, 33'h0);
         frame(lfsr[12], 1'b0, 1'b1);
         frame(lfsr[5], 1'b0, 1'b1);
         rd_entry();
         rd_entry();
      end
      // Full buffer, one waiting, new start: the waiting frame is lost
      frame(1'b1, 1'b0, 1'b1);
      frame(1'b1, 1'b0, 1'b1);
      frame(1'b1, 1'b0, 1'b0);
      frame(1'b1, 1'b1, 1'b1);
      rd_entry();
      rd_entry();
      rd_entry();
      frame(1'b0, 1'b0, 1'b1);
      apb(1'b1, `URBS_OFF_STATUS, 32'h0, 33'h0);
      apb(1'b1, `URBS_OFF_DATA, 32'hff, 33'h0);
      // Unmapped aliases of the control and data words must touch nothing
      apb(1'b1, 32'h14, 32'h0, 33'h0);
      apb(1'b0, 32'h1c, 32'h0, {1'b1, 32'h0});
      rd_entry();
      // Disable with data buffered, then a frame while disabled
      gie_m = 1'b1;
      global_irq_en <= 1'b1;
      frame(1'b1, 1'b0, 1'b0);
      frame(1'b1, 1'b0, 1'b0);
      apb(1'b1, `URBS_OFF_CTRL_B, 32'h80, 33'h0);
      frame(1'b1, 1'b0, 1'b0);
      apb(1'b0, `URBS_OFF_STATUS, 32'h0, 33'h0);
      check({31'h0, rx_irq, rx_pin_claim}, 33'h0, "irq and pin after disable");
      report_and_stop();
   end
endmodule

// [urbs_pkg.sv]
// Types shared by the receive buffer block.
// Assumes the constants header is included by the user.
package urbs_pkg;
   typedef struct packed {
      logic [8:0] data;
      logic fe;
      logic overrun_flag;
      logic pe;
   } urbs_entry_t;

   typedef struct packed {
      urbs_entry_t [1:0] ent;
      logic rd_ptr;
      logic [1:0] cnt;
      logic pend;
      urbs_entry_t pend_ent;
      logic ovr;
      logic rx_complete_irq_en;
      logic rx_en;
      logic tx9;
      logic upm_hi;
      logic upm_lo;
      logic stops;
      logic [2:0] csz;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } urbs_state_t;
endpackage

// [urbs_regs.svh]
// Register offsets, field positions, reset values of the receive buffer block.
// Assumes a 32-bit APB slave; every register is one aligned word.
`ifndef URBS_REGS_SVH
`define URBS_REGS_SVH
`define URBS_OFF_STATUS 4'h0
`define URBS_OFF_CTRL_B 4'h4
`define URBS_OFF_CTRL_C 4'h8
`define URBS_OFF_DATA 4'hc
`define URBS_BIT_RXC 7
`define URBS_BIT_FE 4
`define URBS_BIT_DOR 3
`define URBS_BIT_PE 2
`define URBS_BIT_RX_COMPLETE_IRQ_EN 7
`define URBS_BIT_RECEIVER_ENABLE 4
`define URBS_BIT_RX9 1
`define URBS_BIT_TX9 0
`define URBS_BIT_UPMH 5
`define URBS_BIT_UPML 4
`define URBS_BIT_STOPS 3
`define URBS_CSZ_NINE 3'h7
`define URBS_RST_CSZ 3'h3
`endif

// [urbs_remote_tx.sv]
// Remote serial transmitter as seen past the bit-level receiver: start and frame pulses.
// Assumes the caller invokes send right after a rising edge of mclk.
`timescale 1ns/1ps

module urbs_remote_tx (
   input wire logic mclk,
   output logic frame_valid,
   output logic [8:0] frame_data,
   output logic frame_parity,
   output logic frame_stop1,
   output logic start_detect
);
   initial begin
      frame_valid = 1'b0;
      frame_data = 9'h000;
      frame_parity = 1'b0;
      frame_stop1 = 1'b1;
      start_detect = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gap sets prompt or slow frames; a zero stop bit is a deliberate framing fault
   task automatic send(input logic [8:0] d, input logic p, input logic s, input int gap);
      start_detect <= 1'b1;
      @(posedge mclk);
      start_detect <= 1'b0;
      repeat (gap) @(posedge mclk);
      frame_valid <= 1'b1;
      frame_data <= d;
      frame_parity <= p;
      frame_stop1 <= s;
      @(posedge mclk);
      frame_valid <= 1'b0;
      // Outside a frame the lines hold no meaning, so show the inverse
      frame_data <= ~d;
      frame_parity <= ~p;
      frame_stop1 <= ~s;
   endtask
endmodule

// [urbs_rx_buffer.sv]
// Receive buffer, status flags and parity check of a serial port, APB slave.
// Assumes a bit-level receiver delivers each frame at its first stop bit.
`timescale 1ns/1ps
`include "urbs_regs.svh"

module urbs_rx_buffer import urbs_pkg::*; #(
   parameter int RX_DEPTH = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_valid,
   input wire logic [8:0] frame_data,
   input wire logic frame_parity,
   input wire logic frame_stop1,
   input wire logic start_detect,
   input wire logic global_irq_en,
   output logic rx_irq,
   output logic rx_pin_claim
);

   ////////////////////////////////////////////////////////////////////////
   generate
      if (RX_DEPTH != 2) begin : g_bad_depth
         $error("urbs_rx_buffer serves a two-entry buffer only");
      end
   endgenerate

   urbs_state_t s_q;
   urbs_state_t s_d;

   function automatic logic [8:0] urbs_mask(input logic [2:0] csz);
      logic [8:0] m;
      m = 9'h01f;
      unique case (csz)
         3'h1: m = 9'h03f;
         3'h2: m = 9'h07f;
         3'h3: m = 9'h0ff;
         `URBS_CSZ_NINE: m = 9'h1ff;
         default: m = 9'h01f;
      endcase
      return m;
   endfunction

   logic acc;
   logic wr;
   logic rd;
   logic pop;
   logic nine;
   logic [8:0] fdata;
   logic wr_idx;
   urbs_entry_t head;
   urbs_entry_t newe;
   logic [7:0] rbyte;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      // Accesses outside the register map answer with an error and leave all state alone
      acc = psel & penable & s_q.pready & (paddr[31:4] == 28'h0);
      wr = acc & pwrite;
      rd = acc & ~pwrite;
      head = s_q.ent[s_q.rd_ptr];
      nine = (s_q.csz == `URBS_CSZ_NINE);
      pop = rd & (paddr[3:0] == `URBS_OFF_DATA) & (s_q.cnt != 2'h0);
      // Frame captured with the settings in force on arrival
      fdata = frame_data & urbs_mask(s_q.csz);
      newe.data = fdata;
      newe.fe = ~frame_stop1;
      newe.overrun_flag = 1'b0;
      newe.pe = s_q.upm_hi & (^fdata ^ frame_parity ^ s_q.upm_lo);
      // Read frees the head entry at once
      if (pop) begin
         s_d.rd_ptr = ~s_q.rd_ptr;
         s_d.cnt = s_q.cnt - 2'h1;
      end
      // Status writes are ignored by the flag storage
      if (wr && paddr[3:0] == `URBS_OFF_CTRL_B) begin
         s_d.rx_complete_irq_en = pwdata[`URBS_BIT_RX_COMPLETE_IRQ_EN];
         s_d.rx_en = pwdata[`URBS_BIT_RECEIVER_ENABLE];
         s_d.tx9 = pwdata[`URBS_BIT_TX9];
      end
      if (wr && paddr[3:0] == `URBS_OFF_CTRL_C) begin
         s_d.upm_hi = pwdata[`URBS_BIT_UPMH];
         s_d.upm_lo = pwdata[`URBS_BIT_UPML];
         s_d.stops = pwdata[`URBS_BIT_STOPS];
         s_d.csz = pwdata[2:0];
      end
      // Waiting frame moves in first, keeping arrival order
      wr_idx = s_d.rd_ptr ^ s_d.cnt[0];
      if (s_q.pend && s_d.cnt != 2'h2) begin
         s_d.ent[wr_idx] = s_q.pend_ent;
         s_d.ent[wr_idx].overrun_flag = s_q.ovr;
         s_d.cnt = s_d.cnt + 2'h1;
         s_d.pend = 1'b0;
         s_d.ovr = 1'b0;
      end
      wr_idx = s_d.rd_ptr ^ s_d.cnt[0];
      if (s_q.rx_en && frame_valid) begin
         if (!s_d.pend && s_d.cnt != 2'h2) begin
            s_d.ent[wr_idx] = newe;
            s_d.ent[wr_idx].overrun_flag = s_d.ovr;
            s_d.cnt = s_d.cnt + 2'h1;
            s_d.ovr = 1'b0;
         end else begin
            // A still-waiting frame is overwritten and lost
            if (s_d.pend) begin
               s_d.ovr = 1'b1;
            end
            s_d.pend = 1'b1;
            s_d.pend_ent = newe;
         end
      end
      // New start bit over a waiting frame: that frame is lost; a data read in the same cycle saves it
      if (s_q.rx_en && start_detect && s_q.pend && s_q.cnt == 2'h2 && !pop) begin
         s_d.ovr = 1'b1;
         s_d.pend = 1'b0;
      end
      // Disable flushes in the same edge that clears the enable
      if (!s_d.rx_en) begin
         s_d.cnt = 2'h0;
         s_d.pend = 1'b0;
         s_d.ovr = 1'b0;
      end
      s_d.irq = s_d.rx_complete_irq_en & (s_d.cnt != 2'h0) & global_irq_en;
      // APB: data latched in setup, ready in the first access cycle
      s_d.pready = psel & ~penable;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0;
      rbyte = 8'h00;
      if (psel && !penable) begin
         unique case (paddr[3:0])
            `URBS_OFF_STATUS: begin
               rbyte[`URBS_BIT_RXC] = (s_q.cnt != 2'h0);
               rbyte[`URBS_BIT_FE] = head.fe & (s_q.cnt != 2'h0);
               rbyte[`URBS_BIT_DOR] = head.overrun_flag & (s_q.cnt != 2'h0);
               rbyte[`URBS_BIT_PE] = head.pe & (s_q.cnt != 2'h0);
            end
            `URBS_OFF_CTRL_B: begin
               rbyte[`URBS_BIT_RX_COMPLETE_IRQ_EN] = s_q.rx_complete_irq_en;
               rbyte[`URBS_BIT_RECEIVER_ENABLE] = s_q.rx_en;
               rbyte[`URBS_BIT_RX9] = head.data[8] & nine & (s_q.cnt != 2'h0);
               rbyte[`URBS_BIT_TX9] = s_q.tx9;
            end
            `URBS_OFF_CTRL_C: begin
               rbyte[`URBS_BIT_UPMH] = s_q.upm_hi;
               rbyte[`URBS_BIT_UPML] = s_q.upm_lo;
               rbyte[`URBS_BIT_STOPS] = s_q.stops;
               rbyte[2:0] = s_q.csz;
            end
            `URBS_OFF_DATA: begin
               rbyte = (s_q.cnt != 2'h0) ? head.data[7:0] : 8'h00;
            end
            default: s_d.pslverr = 1'b1;
         endcase
         if (paddr[31:4] != 28'h0) begin
            s_d.pslverr = 1'b1;
            rbyte = 8'h00;
         end
      end
      s_d.prdata = {24'h000000, rbyte};
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.csz <= `URBS_RST_CSZ;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign rx_irq = s_q.irq;
   assign rx_pin_claim = s_q.rx_en;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic dread;
   logic sread;
   assign dread = psel & penable & pready & ~pwrite & (paddr == 32'hc);
   assign sread = psel & ~penable & ~pwrite & (paddr == 32'h0);

   irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
      // A write to the control word may legally drop the request
      (s_q.cnt != 2'h0 && s_q.rx_complete_irq_en && global_irq_en && !dread &&
      !(psel && penable && pwrite && paddr == 32'h4)) |=> rx_irq)
      else $error("interrupt not requested while data buffered");
   irq_no_err_a: assert property (@(posedge mclk) disable iff (!rst_n)
      rx_irq |-> s_q.cnt != 2'h0 && s_q.rx_complete_irq_en && $past(global_irq_en))
      else $error("interrupt without buffered data");
   flush_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !s_q.rx_en |-> s_q.cnt == 2'h0 && !s_q.pend)
      else $error("buffer not flushed while disabled");
   pop_adv_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (dread && s_q.cnt != 2'h0 && !frame_valid && !s_q.pend && s_q.rx_en) |=>
      s_q.cnt == $past(s_q.cnt) - 2'h1 && s_q.rd_ptr != $past(s_q.rd_ptr))
      else $error("data read did not advance buffer");
   rxc_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      sread |=> prdata[7] == $past(s_q.cnt != 2'h0))
      else $error("receive-complete mismatch");
   fe_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (frame_valid && s_q.rx_en && s_q.cnt == 2'h0 && !s_q.pend && !dread &&
      !(psel && penable && pwrite)) |=> s_q.ent[s_q.rd_ptr].fe == !$past(frame_stop1))
      else $error("frame error does not follow stop bit");
   pe_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (frame_valid && s_q.rx_en && !s_q.upm_hi && s_q.cnt == 2'h0 && !s_q.pend &&
      !(psel && penable && pwrite)) |=> !s_q.ent[s_q.rd_ptr].pe)
      else $error("parity error with checking off");
   ovr_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (start_detect && s_q.rx_en && s_q.pend && s_q.cnt == 2'h2 && !dread &&
      !(psel && penable && pwrite)) |=> s_q.ovr && !s_q.pend)
      else $error("overrun not flagged");
   short_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && !penable && paddr == 32'hc && s_q.csz == 3'h0) |=> prdata[31:5] == 27'h0)
      else $error("unused data bits not zero");

   // Buffer order, overrun marking, error and ninth-bit flags, status, flush and interrupt gate
   err_no_pop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && penable && pready && pslverr && !frame_valid && !s_q.pend) |=>
      s_q.cnt == $past(s_q.cnt) && s_q.rd_ptr == $past(s_q.rd_ptr))
      else $error("errored access changed the buffer");

   pop_frees_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (dread && s_q.cnt == 2'h2 && s_q.pend && s_q.rx_en && !frame_valid && !start_detect) |=>
      s_q.cnt == 2'h2 && !s_q.pend)
      else $error("read entry not freed for the waiting frame");

   dor_carry_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (dread && s_q.cnt == 2'h2 && s_q.pend && s_q.ovr && s_q.rx_en && !frame_valid && !start_detect) |=>
      s_q.ent[~s_q.rd_ptr].overrun_flag && !s_q.ovr)
      else $error("lost frame not marked on the next entry");

   dor_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (frame_valid && s_q.rx_en && s_q.cnt != 2'h2 && !s_q.pend && !(psel && penable && pwrite)) |=>
      !s_q.ovr)
      else $error("overrun not cleared by a stored frame");

   full_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (frame_valid && s_q.rx_en && s_q.cnt == 2'h2 && !s_q.pend && !dread && !(psel && penable && pwrite)) |=>
      s_q.cnt == 2'h2 && s_q.pend)
      else $error("frame into a full buffer not held waiting");

   head_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.cnt != 2'h0 && !dread && !(psel && penable && pwrite)) |=>
      s_q.ent[s_q.rd_ptr] == $past(s_q.ent[s_q.rd_ptr]))
      else $error("entry at the read position changed before its read");

   fe_next_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (frame_valid && s_q.rx_en && s_q.cnt == 2'h1 && !s_q.pend && !dread && !(psel && penable && pwrite)) |=>
      s_q.ent[~s_q.rd_ptr].fe == !$past(frame_stop1))
      else $error("frame error not stored with its entry");

   pe_off_next_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (frame_valid && s_q.rx_en && !s_q.upm_hi && s_q.cnt == 2'h1 && !s_q.pend && !dread &&
      !(psel && penable && pwrite)) |=> !s_q.ent[~s_q.rd_ptr].pe)
      else $error("parity error stored with checking off");

   ninth_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (frame_valid && s_q.rx_en && s_q.csz == `URBS_CSZ_NINE && s_q.cnt == 2'h0 && !s_q.pend &&
      !(psel && penable && pwrite)) |=> s_q.ent[s_q.rd_ptr].data == $past(frame_data))
      else $error("nine-bit character not stored whole");

   nine_short_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && !penable && paddr == 32'h4 && s_q.csz != `URBS_CSZ_NINE) |=>
      !prdata[`URBS_BIT_RX9])
      else $error("ninth bit set for a short character");

   stat_empty_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (sread && s_q.cnt == 2'h0) |=>
      prdata == 32'h0)
      else $error("status not clear with the buffer empty");

   wr_status_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && penable && pready && pwrite && paddr == 32'h0 && !frame_valid && !s_q.pend) |=>
      s_q.cnt == $past(s_q.cnt) && s_q.ent == $past(s_q.ent))
      else $error("status write altered the buffer");

   dis_flush_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && penable && pready && pwrite && paddr == 32'h4 && !pwdata[`URBS_BIT_RECEIVER_ENABLE]) |=>
      s_q.cnt == 2'h0 && !rx_irq && !rx_pin_claim)
      else $error("disable did not flush at once");

   frame_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (frame_valid && !s_q.rx_en && !(psel && penable && pwrite)) |=>
      s_q.cnt == 2'h0 && !s_q.pend)
      else $error("frame taken while the receiver is off");

   irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !global_irq_en |=>
      !rx_irq)
      else $error("interrupt requested with the global gate closed");

   full_c: cover property (@(posedge mclk) disable iff (!rst_n) s_q.cnt == 2'h2 && s_q.pend);
   ovr_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(s_q.ovr));
   irq_c: cover property (@(posedge mclk) disable iff (!rst_n) rx_irq ##1 dread);
   dor_c: cover property (@(posedge mclk) disable iff (!rst_n) dread ##1 s_q.ent[s_q.rd_ptr].overrun_flag);
   flush_c: cover property (@(posedge mclk) disable iff (!rst_n) $fell(rx_pin_claim));
endmodule
